// File: mem_ctl_regs.svh
// timing constants and reset values for the memory access completion control
`ifndef MEM_CTL_REGS_SVH
`define MEM_CTL_REGS_SVH
`define CLK_FREQ_HZ 10000000
`define NOREQ_TIMEOUT_US 100
// cycles in the no-request timeout, rounded down as a longest time
`define NOREQ_TIMEOUT_CYC ((`NOREQ_TIMEOUT_US * (`CLK_FREQ_HZ / 1000000)))
`define FLAG_RESET 1'b0
`endif

// File: mem_ctl_pkg.sv
// types for the memory access completion control
package mem_ctl_pkg;
    // access requests from the main sequence, one-cycle pulses
    typedef struct packed {
        logic rd;
        logic wr;
        logic rw;
    } req_s;
    // memory bus levels and pulses driven by the processor
    typedef struct packed {
        logic cycle_req;
        logic rd_level;
        logic wr_level;
        logic wr_restart;
        logic data_xfer;
    } bus_out_s;
    // operator console inputs
    typedef struct packed {
        logic mem_stop_key;
        logic addr_stop_sw;
        logic addr_match;
        logic split_override_sw;
        logic mem_disable_sw;
        logic mem_continue_key;
        logic key_timing_pulse;
    } console_s;
endpackage

// File: mem_access_ctl.sv
// memory access completion control: request flags, restarts, timeout, split cycle
// Function
// - ack pulse clears pending request
// - write ack: write restart, data, completion
// - read completion waits for read restart
// - completion clears read flag, returns sequence
// - memory stop blocks restart completion
// - continue key at key timing completes
// - read/write first half acts as read
// - rw restart: write restart, data, completion
// - 100 us no-request timeout flags nonexistent memory
// - nonexistent pulse sets error flag
// - disable off: timeout simulates acknowledge
// - addr timing sets split flag on stop
// - split flag splits read/write into two
// - switch overrides split behaviour
// - stop sync rewrites word on other restart
// - requests set and clear read/write flags
// - cycle request only with read or write
`timescale 1ns/1ps
`include "mem_ctl_regs.svh"
// one clock, synchronous inputs; all timing pulses are one cycle wide.
// limitation: only one access is tracked at a time, a second request
// before completion restarts the flags and the timeout.
// trade-off: the timeout is a down counter instead of a retriggered
// delay, so its length is exact in cycles but tied to the clock rate.
module mem_access_ctl
    import mem_ctl_pkg::*;
#(
    parameter int unsigned TIMEOUT_CYC = `NOREQ_TIMEOUT_CYC
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire req_s req,
    input wire logic rw_restart,
    input wire logic fetch_timing_pulse,
    input wire logic addr_cycle_timing_pulse,
    input wire console_s con,
    input wire logic mem_ack,
    input wire logic mem_read_restart,
    output bus_out_s bus_o,
    output logic access_done_pulse,
    output logic continue_done_pulse,
    output logic addr_ack_pulse,
    output logic nxm_pulse,
    output logic nxm_error,
    output logic halted
);
    localparam int CW = $clog2(TIMEOUT_CYC + 1);

    // simulated acknowledge from a timeout when the disable switch is off;
    // shared by the request clear and the extra read completion
    function automatic logic sim_ack(input logic expired, input logic disable_sw);
        return expired & ~disable_sw;
    endfunction

    // request and completion state, one flop per bus flag role
    logic pending_request_ff_q, pending_request_ff_d;
    logic read_flag_ff_q, read_flag_ff_d;
    logic write_flag_ff_q, write_flag_ff_d;
    logic mem_halt_ff_q, mem_halt_ff_d;
    logic split_q, split_d;
    logic stop_sync_q, stop_sync_d;
    logic nxm_error_q, nxm_error_d;
    logic [CW-1:0] tmo_q, tmo_d;
    bus_out_s bus_q, bus_d;
    logic done_q, done_d, cont_q, cont_d, ack_q, ack_d, nxm_q, nxm_d;

    // effective request pulses after split-cycle steering
    logic rw_req, rd_req, wr_req, any_req, rw_wr_restart, split_wr_req;
    logic ack, nxm, read_done, write_done;

    // steering and completion events, all single-cycle
    // split flag turns the fetch read/write into a plain read and the
    // processor restart into a plain write, so a stop never leaves
    // memory held between the two halves
    // the timeout fires one cycle before the counter empties; a request
    // in that same cycle reloads it instead, so no false expiry
    always_comb begin
        rw_req = (req.rw | fetch_timing_pulse) & ~split_q;
        rd_req = req.rd | ((req.rw | fetch_timing_pulse) & split_q);
        split_wr_req = rw_restart & split_q;
        wr_req = req.wr | split_wr_req;
        any_req = rw_req | rd_req | wr_req;
        rw_wr_restart = rw_restart & ~split_q;
        // timeout expiry with a request still pending, unless stopped
        nxm = pending_request_ff_q && tmo_q == CW'(1) && !any_req && !mem_halt_ff_q;
        ack = (mem_ack & pending_request_ff_q) | sim_ack(nxm, con.mem_disable_sw);
        read_done = (mem_read_restart & read_flag_ff_q) | (sim_ack(nxm, con.mem_disable_sw) & read_flag_ff_q);
        write_done = (ack & ~read_flag_ff_q & write_flag_ff_q) | rw_wr_restart;
    end

    // request flags, halt, split and stop sync state
    always_comb begin
        pending_request_ff_d = pending_request_ff_q;
        read_flag_ff_d = read_flag_ff_q;
        write_flag_ff_d = write_flag_ff_q;
        mem_halt_ff_d = mem_halt_ff_q;
        split_d = split_q;
        stop_sync_d = stop_sync_q;
        nxm_error_d = nxm_error_q | nxm;
        done_d = 1'b0;
        cont_d = 1'b0;
        ack_d = ack;
        nxm_d = nxm;
        bus_d = '0;
        if (ack) begin
            pending_request_ff_d = 1'b0;
        end
        // a restart arriving while halted is simply lost; the continue key
        // supplies the return instead, so nothing is queued here
        // halted access: restarts give no completion until continue
        if ((read_done | write_done) & ~mem_halt_ff_q) begin
            done_d = 1'b1;
            read_flag_ff_d = 1'b0;
        end
        if (write_done) begin
            bus_d.wr_restart = 1'b1;
            bus_d.data_xfer = 1'b1;
        end
        if (rw_wr_restart) begin
            stop_sync_d = 1'b0;
        end
        // key timing: continue returns to the waiting sequence; any other
        // restart first lets a held read/write finish by rewriting the word
        // continue has priority, since a halted access still owns memory
        if (con.key_timing_pulse) begin
            if (con.mem_continue_key && mem_halt_ff_q) begin
                cont_d = 1'b1;
                mem_halt_ff_d = 1'b0;
            end else if (stop_sync_q) begin
                bus_d.wr_restart = 1'b1;
                bus_d.data_xfer = 1'b1;
                stop_sync_d = 1'b0;
            end
        end
        // split flag is reloaded every address cycle rather than only set,
        // so it drops again once the stop key and switch are released
        // the maintenance switch keeps read/write cycles whole
        if (addr_cycle_timing_pulse) begin
            split_d = (con.mem_stop_key | con.addr_stop_sw) & ~con.split_override_sw;
        end
        // a new request overrides completion clears in the same cycle;
        // the stop flag is judged afresh for each access
        if (any_req) begin
            read_flag_ff_d = rd_req | rw_req;
            write_flag_ff_d = wr_req | rw_req;
            pending_request_ff_d = 1'b1;
            mem_halt_ff_d = con.mem_stop_key | (con.addr_stop_sw & con.addr_match);
        end
        // stop sync marks memory held by an unsplit read/write
        // cleared again by the processor's own restart or by key timing
        if (rw_req) begin
            stop_sync_d = 1'b1;
        end
        // cycle request needs a read or write level too
        bus_d.cycle_req = pending_request_ff_d & (read_flag_ff_d | write_flag_ff_d);
        bus_d.rd_level = read_flag_ff_d;
        bus_d.wr_level = write_flag_ff_d;
    end

    // counter parks at zero once expired, so a stale pending request
    // gives exactly one nonexistent-memory pulse, or none if halted at expiry, not a train of them
    // zero also marks an idle bus after reset
    // no-request timeout counter, reloaded on each request
    always_comb begin
        if (any_req) begin
            tmo_d = CW'(TIMEOUT_CYC);
        end else if (tmo_q != '0) begin
            tmo_d = tmo_q - CW'(1);
        end else begin
            tmo_d = tmo_q;
        end
    end

    // state registers; reset is synchronous and loads constants only
    // outputs of these registers feed the ports directly
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pending_request_ff_q <= `FLAG_RESET;
            read_flag_ff_q <= `FLAG_RESET;
            write_flag_ff_q <= `FLAG_RESET;
            mem_halt_ff_q <= `FLAG_RESET;
            split_q <= `FLAG_RESET;
            stop_sync_q <= `FLAG_RESET;
            nxm_error_q <= `FLAG_RESET;
            tmo_q <= '0;
            bus_q <= '0;
            done_q <= 1'b0;
            cont_q <= 1'b0;
            ack_q <= 1'b0;
            nxm_q <= 1'b0;
        end else begin
            pending_request_ff_q <= pending_request_ff_d;
            read_flag_ff_q <= read_flag_ff_d;
            write_flag_ff_q <= write_flag_ff_d;
            mem_halt_ff_q <= mem_halt_ff_d;
            split_q <= split_d;
            stop_sync_q <= stop_sync_d;
            nxm_error_q <= nxm_error_d;
            tmo_q <= tmo_d;
            bus_q <= bus_d;
            done_q <= done_d;
            cont_q <= cont_d;
            ack_q <= ack_d;
            nxm_q <= nxm_d;
        end
    end

    // bus levels and pulses are registered too, giving the memory side
    // clean edges at the cost of one cycle of latency
    // every output straight from a flip-flop
    assign bus_o = bus_q;
    assign access_done_pulse = done_q;
    assign continue_done_pulse = cont_q;
    assign addr_ack_pulse = ack_q;
    assign nxm_pulse = nxm_q;
    assign nxm_error = nxm_error_q;
    assign halted = mem_halt_ff_q;
endmodule

// File: mem_access_ctl_checker.sv
// port checker for the memory access completion control
`timescale 1ns/1ps
module mem_access_ctl_checker
    import mem_ctl_pkg::*;
(
    input wire logic sys_clk,
    input wire logic srst,
    input wire req_s req,
    input wire logic rw_restart,
    input wire logic fetch_timing_pulse,
    input wire logic addr_cycle_timing_pulse,
    input wire console_s con,
    input wire logic mem_ack,
    input wire logic mem_read_restart,
    input wire bus_out_s bus_o,
    input wire logic access_done_pulse,
    input wire logic continue_done_pulse,
    input wire logic addr_ack_pulse,
    input wire logic nxm_pulse,
    input wire logic nxm_error,
    input wire logic halted
);
    // one clock domain, so clock and reset are given once
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    property p_ack; mem_ack && bus_o.cycle_req |=> addr_ack_pulse && !bus_o.cycle_req; endproperty
    a_ack: assert property (p_ack) else $error("ack did not clear request");
    property p_wr; mem_ack && bus_o.cycle_req && !bus_o.rd_level && !halted |=> bus_o.wr_restart && access_done_pulse; endproperty
    a_wr: assert property (p_wr) else $error("write ack without restart");
    property p_rdw; mem_ack && bus_o.rd_level && !mem_read_restart |=> !access_done_pulse; endproperty
    a_rdw: assert property (p_rdw) else $error("read completed on ack");
    property p_rdd; mem_read_restart && bus_o.rd_level && !halted |=> access_done_pulse; endproperty
    a_rdd: assert property (p_rdd) else $error("read restart gave no completion");
    property p_halt; halted && !con.key_timing_pulse |=> !access_done_pulse; endproperty
    a_halt: assert property (p_halt) else $error("completion while stopped");
    property p_cont; halted && con.mem_continue_key && con.key_timing_pulse |=> continue_done_pulse; endproperty
    a_cont: assert property (p_cont) else $error("continue gave no return");
    property p_req; bus_o.cycle_req |-> bus_o.rd_level || bus_o.wr_level; endproperty
    a_req: assert property (p_req) else $error("bare cycle request");
    property p_err; nxm_pulse || nxm_error |=> nxm_error; endproperty
    a_err: assert property (p_err) else $error("error flag not held");
endmodule
bind mem_access_ctl mem_access_ctl_checker mem_access_ctl_checker_inst (.*);

// File: mem_bus_model.sv
// behavioural memory module answering on the memory bus
`timescale 1ns/1ps
module mem_bus_model
    import mem_ctl_pkg::*;
(
    input wire logic sys_clk,
    input wire logic present,
    input wire bus_out_s bus_o,
    output logic mem_ack = 0,
    output logic mem_read_restart = 0
);
    // one access at a time; an absent module never answers
    always @(negedge sys_clk) begin
        if (present && bus_o.cycle_req) begin
            repeat (3) @(negedge sys_clk);
            mem_ack = 1;
            @(negedge sys_clk);
            mem_ack = 0;
            if (bus_o.rd_level) begin
                repeat (3) @(negedge sys_clk);
                mem_read_restart = 1;
                @(negedge sys_clk);
                mem_read_restart = 0;
            end
        end
    end
endmodule

// File: mem_access_ctl_bench.sv
// self-checking bench for the memory access completion control
`timescale 1ns/1ps
module mem_access_ctl_bench
    import mem_ctl_pkg::*;
;
    logic sys_clk = 0, srst = 1, rw_restart = 0, present = 1;
    logic fetch_timing_pulse = 0, addr_cycle_timing_pulse = 0;
    logic mem_ack, mem_read_restart, access_done_pulse, continue_done_pulse;
    logic addr_ack_pulse, nxm_pulse, nxm_error, halted;
    req_s req = '0;
    console_s con = '0;
    bus_out_s bus_o;
    int bad_count = 0, compares = 0, cyc = 0;
    always #50 sys_clk = ~sys_clk;
    mem_access_ctl #(.TIMEOUT_CYC(20)) mem_access_ctl_inst (.*);
    mem_bus_model mem_bus_model_inst (.*);
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        if (bad_count == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // one request pulse, then a bounded wait for completion
    task automatic run(input req_s r, input logic f, input logic [1:0] lv);
        int n = 0;
        req = r;
        fetch_timing_pulse = f;
        @(negedge sys_clk) req = '0;
        fetch_timing_pulse = 0;
        chk({bus_o.cycle_req, bus_o.rd_level, bus_o.wr_level}, {1'h1, lv});
        while (access_done_pulse !== 1'b1 && n++ < 60) @(negedge sys_clk);
        chk(access_done_pulse, 1'h1);
    endtask
    // write then read back to back
    task automatic t_basic();
        run(3'h2, 1'h0, 2'h1);
        chk({bus_o.wr_restart, bus_o.data_xfer, addr_ack_pulse, bus_o.cycle_req}, 4'hE);
        run(3'h4, 1'h0, 2'h2);
        chk({bus_o.wr_restart, addr_ack_pulse}, 2'h0);
        @(negedge sys_clk) chk(bus_o.rd_level, 1'h0);
    endtask
    // held read/write, or split into two requests when a stop may come
    task automatic t_rw(input logic s, input logic o);
        logic e;
        e = s & !o;
        con.addr_stop_sw = s;
        con.split_override_sw = o;
        addr_cycle_timing_pulse = 1;
        @(negedge sys_clk) addr_cycle_timing_pulse = 0;
        run(3'h0, 1'h1, {1'h1, !e});
        rw_restart = 1;
        @(negedge sys_clk) rw_restart = 0;
        chk({bus_o.wr_restart, access_done_pulse, bus_o.cycle_req}, {!e, !e, e});
        if (e) run(3'h0, 1'h0, 2'h1);
        con.addr_stop_sw = 0;
        con.split_override_sw = 0;
    endtask
    // key timing without continue rewrites a held read/write word
    task automatic t_sync();
        run(3'h0, 1'h1, 2'h3);
        con.key_timing_pulse = 1;
        @(negedge sys_clk) con.key_timing_pulse = 0;
        chk({bus_o.wr_restart, bus_o.data_xfer, continue_done_pulse}, 3'h6);
    endtask
    // absent memory: timeout, error flag, simulated completion
    task automatic t_nxm(input req_s r, input logic [1:0] lv);
        present = 0;
        run(r, 1'h0, lv);
        chk({nxm_pulse, nxm_error, bus_o.cycle_req}, 3'h6);
        present = 1;
    endtask
    // stop holds completion back until the continue key
    task automatic t_stop();
        con.mem_stop_key = 1;
        req = 3'h4;
        @(negedge sys_clk) req = '0;
        repeat (30) @(negedge sys_clk) chk({access_done_pulse, nxm_pulse}, 2'h0);
        chk(halted, 1'h1);
        con = 7'h03;
        @(negedge sys_clk) con = '0;
        chk(continue_done_pulse, 1'h1);
    endtask
    initial begin
        repeat (20) @(negedge sys_clk);
        srst = 0;
        @(negedge sys_clk);
        t_basic();
        t_rw(0, 0);
        t_rw(1, 0);
        t_rw(1, 1);
        t_sync();
        t_nxm(3'h2, 2'h1);
        t_nxm(3'h4, 2'h2);
        t_stop();
        give_verdict();
    end
    // hang guard, far beyond the roughly 160 cycles needed
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 3000) begin
            bad_count++;
            give_verdict();
        end
    end
endmodule
